// ---- hdl/cffim_fault_mask.v ----
`timescale 1ns/1ps
`include "cffim_map.vh"
// Notes on behaviour
// - fault_status_a bit 0 reads 1 while input 1 is overvoltage; cleared at reset.
// - fault_status_b bit 6 reads 1 while switching stops for system overvoltage.
// - fault_status_b bit 2 reads 1 while the thermal shutdown detector level is high.
// - all mask bits reset to 0 at power-on and on register-reset command.
// - mask_a bit 7 gates pulse for entering input-current regulation.
// - mask_a bit 6 gates pulse for entering input-voltage regulation.
// - mask_a bit 5 gates pulse for host watchdog expiry.
// - mask_a bit 4 gates interrupt for weak source detection.
// - mask_a bit 3 gates interrupt for each power-good toggle.
// - mask_a bits 2..0 gate presence changes of input 2, input 1, bus input.
// - mask_b bit 7 gates interrupt on charging status change.
// - mask_b bit 6 gates interrupt on current optimizer status change.
// - mask_b bit 4 gates interrupt on bus input status change.
// - mask_b bit 2 gates interrupt on entering thermal regulation.
// - mask_b bit 1 gates interrupt on battery presence change.
// - mask_b bit 0 gates interrupt on port detection status change.
// - mask_c bits 6 and 5 gate data-line detect done and one-shot conversion done.
// - mask_c bit 4 gates pulse on entering or leaving minimum system regulation.
// - mask_c bits 3..0 gate fast, trickle, precharge and top-off timer expiry.
module cffim_fault_mask (
  input wire core_clk,
  input wire rst,
  input wire regRstCmd,
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  input wire input1OvDet,
  input wire sysShortDet,
  input wire sysOvStopDet,
  input wire thermalShutDet,
  input wire inputCurrentRegEnter,
  input wire inputVoltageRegEnter,
  input wire hostWatchdogExpire,
  input wire weakSourceDet,
  input wire powerGood,
  input wire input2Present,
  input wire input1Present,
  input wire busInputPresent,
  input wire chargeStateChange,
  input wire optimizerStateChange,
  input wire busInputStateChange,
  input wire thermalRegEnter,
  input wire batteryPresent,
  input wire portDetectChange,
  input wire dataLineDetectDone,
  input wire conversionDone,
  input wire minSysRegChange,
  input wire fastChargeTimerExpire,
  input wire trickleTimerExpire,
  input wire prechargeTimerExpire,
  input wire topoffTimerExpire,
  output wire irqPulse
);
  // detector levels come from the analog side, so two stages first
  localparam NSYNC = 23;
  reg [NSYNC-1:0] syncA;
  reg [NSYNC-1:0] syncB;
  reg [NSYNC-1:0] prevB;
  wire [NSYNC-1:0] rawIn;
  reg [7:0] charger_irq_mask_a;
  reg [7:0] charger_irq_mask_b;
  reg [7:0] charger_irq_mask_c;
  reg input1_overvoltage_flag;
  reg system_rail_short_flag;
  reg system_rail_overvoltage_flag;
  reg thermal_shutdown_flag;
  wire [NSYNC-1:0] rise;
  wire [`CFFIM_NUM_EVT-1:0] events;
  wire [`CFFIM_NUM_EVT-1:0] masks;
  wire pgToggle;
  wire [7:0] next_regRdData;
  reg [7:0] rdMux;

  assign rawIn = {
    input1OvDet,
    sysShortDet,
    sysOvStopDet,
    thermalShutDet,
    inputCurrentRegEnter,
    inputVoltageRegEnter,
    hostWatchdogExpire,
    weakSourceDet,
    powerGood,
    input2Present,
    input1Present,
    busInputPresent,
    chargeStateChange,
    optimizerStateChange,
    busInputStateChange,
    thermalRegEnter,
    batteryPresent,
    portDetectChange,
    dataLineDetectDone,
    conversionDone,
    minSysRegChange,
    fastChargeTimerExpire,
    trickleTimerExpire};

  // last two timers kept apart: [1] precharge, [0] top-off
  reg [1:0] tailA;
  reg [1:0] tailB;
  reg [1:0] tailPrev;
  wire [1:0] tailRise;

  always @(posedge core_clk) begin
    if (rst) begin
      syncA <= {NSYNC{1'b0}};
      syncB <= {NSYNC{1'b0}};
      prevB <= {NSYNC{1'b0}};
      tailA <= {2{1'b0}};
      tailB <= {2{1'b0}};
      tailPrev <= {2{1'b0}};
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
      prevB <= syncB;
      tailA <= {prechargeTimerExpire, topoffTimerExpire};
      tailB <= tailA;
      tailPrev <= tailB;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_edge
      assign rise[g] = syncB[g] & ~prevB[g];
    end
  endgenerate

  assign tailRise = tailB & ~tailPrev;

  // presence inputs are levels: any change counts, rising or falling
  assign pgToggle = syncB[14] ^ prevB[14];

  // one named strobe per event, high for one cycle
  wire evtInputCurrentReg = rise[18];
  wire evtInputVoltageReg = rise[17];
  wire evtHostWatchdog = rise[16];
  wire evtWeakSource = rise[15];
  wire evtPowerGood = pgToggle;
  wire evtInput2Presence = syncB[13] ^ prevB[13];
  wire evtInput1Presence = syncB[12] ^ prevB[12];
  wire evtBusPresence = syncB[11] ^ prevB[11];
  wire evtChargeState = rise[10];
  wire evtOptimizerState = rise[9];
  wire evtBusInputState = rise[8];
  wire evtThermalReg = rise[7];
  wire evtBatteryPresence = syncB[6] ^ prevB[6];
  wire evtPortDetect = rise[5];
  wire evtDataLineDone = rise[4];
  wire evtConversionDone = rise[3];
  // minimum system regulation counts on entry and on exit alike
  wire evtMinSysReg = syncB[2] ^ prevB[2];
  wire evtFastTimer = rise[1];
  wire evtTrickleTimer = rise[0];
  wire evtPrechargeTimer = tailRise[1];
  wire evtTopoffTimer = tailRise[0];

  // named mask fields; reserved positions always hold 0
  wire input_current_regulation_irq_mask;
  wire input_voltage_regulation_irq_mask;
  wire host_watchdog_irq_mask;
  wire weak_source_irq_mask;
  wire power_good_irq_mask;
  wire input2_presence_irq_mask;
  wire input1_presence_irq_mask;
  wire bus_input_presence_irq_mask;
  wire charge_state_irq_mask;
  wire current_optimizer_irq_mask;
  wire maskBRsvd5;
  wire bus_input_state_irq_mask;
  wire maskBRsvd3;
  wire thermal_regulation_irq_mask;
  wire battery_presence_irq_mask;
  wire port_detect_done_irq_mask;
  wire maskCRsvd7;
  wire data_line_detect_done_irq_mask;
  wire conversion_done_irq_mask;
  wire min_system_regulation_irq_mask;
  wire fast_charge_timer_irq_mask;
  wire trickle_timer_irq_mask;
  wire precharge_timer_irq_mask;
  wire topoff_timer_irq_mask;
  assign {input_current_regulation_irq_mask,
    input_voltage_regulation_irq_mask,
    host_watchdog_irq_mask,
    weak_source_irq_mask,
    power_good_irq_mask,
    input2_presence_irq_mask,
    input1_presence_irq_mask,
    bus_input_presence_irq_mask} = charger_irq_mask_a;
  assign {charge_state_irq_mask,
    current_optimizer_irq_mask,
    maskBRsvd5,
    bus_input_state_irq_mask,
    maskBRsvd3,
    thermal_regulation_irq_mask,
    battery_presence_irq_mask,
    port_detect_done_irq_mask} = charger_irq_mask_b;
  assign {maskCRsvd7,
    data_line_detect_done_irq_mask,
    conversion_done_irq_mask,
    min_system_regulation_irq_mask,
    fast_charge_timer_irq_mask,
    trickle_timer_irq_mask,
    precharge_timer_irq_mask,
    topoff_timer_irq_mask} = charger_irq_mask_c;

  // event order matches mask bit order: mask_a[7:0], mask_b[7:0], mask_c[7:0]
  assign events = {
    evtInputCurrentReg,
    evtInputVoltageReg,
    evtHostWatchdog,
    evtWeakSource,
    evtPowerGood,
    evtInput2Presence,
    evtInput1Presence,
    evtBusPresence,
    evtChargeState,
    evtOptimizerState,
    1'b0,
    evtBusInputState,
    1'b0,
    evtThermalReg,
    evtBatteryPresence,
    evtPortDetect,
    1'b0,
    evtDataLineDone,
    evtConversionDone,
    evtMinSysReg,
    evtFastTimer,
    evtTrickleTimer,
    evtPrechargeTimer,
    evtTopoffTimer};
  assign masks = {
    input_current_regulation_irq_mask,
    input_voltage_regulation_irq_mask,
    host_watchdog_irq_mask,
    weak_source_irq_mask,
    power_good_irq_mask,
    input2_presence_irq_mask,
    input1_presence_irq_mask,
    bus_input_presence_irq_mask,
    charge_state_irq_mask,
    current_optimizer_irq_mask,
    maskBRsvd5,
    bus_input_state_irq_mask,
    maskBRsvd3,
    thermal_regulation_irq_mask,
    battery_presence_irq_mask,
    port_detect_done_irq_mask,
    maskCRsvd7,
    data_line_detect_done_irq_mask,
    conversion_done_irq_mask,
    min_system_regulation_irq_mask,
    fast_charge_timer_irq_mask,
    trickle_timer_irq_mask,
    precharge_timer_irq_mask,
    topoff_timer_irq_mask};

  cffim_pulse_gate #(
    .WIDTH(`CFFIM_NUM_EVT)
  ) u_gate (
    .core_clk(core_clk),
    .rst(rst),
    .eventIn(events),
    .maskIn(masks),
    .irqPulse(irqPulse)
  );

  // writes to the flag registers match no strobe and are dropped
  wire wrMaskA = regWrite && (regAddr == `CFFIM_ADDR_MASK_A);
  wire wrMaskB = regWrite && (regAddr == `CFFIM_ADDR_MASK_B);
  wire wrMaskC = regWrite && (regAddr == `CFFIM_ADDR_MASK_C);

  // mask registers: register-reset wins over a write in the same cycle
  always @(posedge core_clk) begin
    if (rst || regRstCmd) begin
      charger_irq_mask_a <= `CFFIM_REG_RESET;
    end else if (wrMaskA) begin
      charger_irq_mask_a <= regWrData & `CFFIM_MASK_A_WR;
    end
  end

  always @(posedge core_clk) begin
    if (rst || regRstCmd) begin
      charger_irq_mask_b <= `CFFIM_REG_RESET;
    end else if (wrMaskB) begin
      charger_irq_mask_b <= regWrData & `CFFIM_MASK_B_WR;
    end
  end

  always @(posedge core_clk) begin
    if (rst || regRstCmd) begin
      charger_irq_mask_c <= `CFFIM_REG_RESET;
    end else if (wrMaskC) begin
      charger_irq_mask_c <= regWrData & `CFFIM_MASK_C_WR;
    end
  end

  // synchronised flag levels; flags follow them, not latched
  wire input1OvLevel = syncB[22];
  wire sysShortLevel = syncB[21];
  wire sysOvLevel = syncB[20];
  wire thermalShutLevel = syncB[19];

  // flags follow the synchronised detector levels
  always @(posedge core_clk) begin
    if (rst) begin
      input1_overvoltage_flag <= 1'b0;
      system_rail_short_flag <= 1'b0;
      system_rail_overvoltage_flag <= 1'b0;
      thermal_shutdown_flag <= 1'b0;
    end else begin
      input1_overvoltage_flag <= input1OvLevel;
      system_rail_short_flag <= sysShortLevel;
      system_rail_overvoltage_flag <= sysOvLevel;
      thermal_shutdown_flag <= thermalShutLevel;
    end
  end

  // read decode; unmapped addresses read zero
  always @* begin
    rdMux = `CFFIM_DATA_ZERO;
    if (regAddr == `CFFIM_ADDR_FAULT_A) begin
      rdMux[`CFFIM_BIT_IN1_OV] = input1_overvoltage_flag;
    end else if (regAddr == `CFFIM_ADDR_FAULT_B) begin
      rdMux[`CFFIM_BIT_SYS_SHORT] = system_rail_short_flag;
      rdMux[`CFFIM_BIT_SYS_OV] = system_rail_overvoltage_flag;
      rdMux[`CFFIM_BIT_TSHUT] = thermal_shutdown_flag;
    end else if (regAddr == `CFFIM_ADDR_MASK_A) begin
      rdMux = charger_irq_mask_a;
    end else if (regAddr == `CFFIM_ADDR_MASK_B) begin
      rdMux = charger_irq_mask_b;
    end else if (regAddr == `CFFIM_ADDR_MASK_C) begin
      rdMux = charger_irq_mask_c;
    end
  end
  assign next_regRdData = rdMux;

  always @(posedge core_clk) begin
    if (rst) begin
      regRdData <= `CFFIM_DATA_ZERO;
    end else begin
      regRdData <= next_regRdData;
    end
  end
endmodule // cffim_fault_mask

// ---- hdl/cffim_map.vh ----
`ifndef CFFIM_MAP_VH
`define CFFIM_MAP_VH
// register addresses on the register port
`define CFFIM_ADDR_FAULT_A 8'h26
`define CFFIM_ADDR_FAULT_B 8'h27
`define CFFIM_ADDR_MASK_A 8'h28
`define CFFIM_ADDR_MASK_B 8'h29
`define CFFIM_ADDR_MASK_C 8'h2a
`define CFFIM_REG_RESET 8'h00
`define CFFIM_DATA_ZERO 8'h00
// writable bits per register; the rest read zero
`define CFFIM_MASK_A_WR 8'hff
`define CFFIM_MASK_B_WR 8'hd7
`define CFFIM_MASK_C_WR 8'h7f
// field positions
`define CFFIM_BIT_IN1_OV 0
`define CFFIM_BIT_SYS_SHORT 7
`define CFFIM_BIT_SYS_OV 6
`define CFFIM_BIT_TSHUT 2
// number of event positions, one per mask bit, the three reserved positions included
`define CFFIM_NUM_EVT 24
`endif

// ---- hdl/cffim_pulse_gate.v ----
`timescale 1ns/1ps
// one mask bit per event; a set bit stops that event from reaching the output
module cffim_pulse_gate #(
  parameter WIDTH = 24
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] eventIn,
  input wire [WIDTH-1:0] maskIn,
  output reg irqPulse
);
  wire [WIDTH-1:0] passed;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_gate
      assign passed[i] = eventIn[i] & ~maskIn[i];
    end
  endgenerate
  always @(posedge core_clk) begin
    if (rst) begin
      irqPulse <= 1'b0;
    end else begin
      irqPulse <= |passed;
    end
  end
endmodule // cffim_pulse_gate

// ---- test/cffim_event_src.sv ----
`timescale 1ns/1ps
// stands in for the analog detectors; a flip bit toggles that level
module cffim_event_src (
  input wire core_clk,
  input wire rst,
  input wire [27:0] flip,
  output reg [27:0] lvl
);
  always @(posedge core_clk) begin
    if (rst) begin
      lvl <= 28'h0000000;
    end else begin
      lvl <= lvl ^ flip;
    end
  end
endmodule // cffim_event_src

// ---- test/cffim_fault_mask_properties.sv ----
`timescale 1ns/1ps
module cffim_fault_mask_properties (
  input wire core_clk,
  input wire rst,
  input wire regRstCmd,
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regRdData,
  input wire input1OvDet,
  input wire sysOvStopDet,
  input wire irqPulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_reset_quiet: assert property ($past(rst) |-> !irqPulse && regRdData == 8'h00)
    else $error("outputs busy after reset");
  chk_mask_a_rw: assert property (
    regWrite && !regRstCmd && regAddr == 8'h28 ##1 regAddr == 8'h28
    |=> regRdData == $past(regWrData, 2)) else $error("mask a readback wrong");
  chk_mask_b_reserved: assert property (
    regWrite && !regRstCmd && regAddr == 8'h29 ##1 regAddr == 8'h29
    |=> regRdData == ($past(regWrData, 2) & 8'hd7)) else $error("mask b readback wrong");
  chk_reg_reset_clear: assert property (
    regRstCmd ##1 (regAddr == 8'h28 && !regWrite) |=> regRdData == 8'h00)
    else $error("mask not cleared");
  chk_flag_reserved: assert property (regAddr == 8'h27 |=> (regRdData & 8'h3b) == 8'h00)
    else $error("reserved flag bit set");
  chk_unmapped_zero: assert property (
    regAddr < 8'h26 || regAddr > 8'h2a |=> regRdData == 8'h00) else $error("unmapped read");
  chk_ov_flag: assert property ((input1OvDet && regAddr == 8'h26) [*5] |=> regRdData[0])
    else $error("overvoltage flag missing");
  chk_sysov_flag: assert property ((sysOvStopDet && regAddr == 8'h27) [*5] |=> regRdData[6])
    else $error("system flag missing");
  cover property (irqPulse);
  cover property (regRstCmd);
  cover property (regWrite && regAddr == 8'h2a);
endmodule // cffim_fault_mask_properties
bind cffim_fault_mask cffim_fault_mask_properties chk (.core_clk, .rst, .regRstCmd, .regWrite,
  .regAddr, .regWrData, .regRdData, .input1OvDet, .sysOvStopDet, .irqPulse);

// ---- test/cffim_fault_mask_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, got, exp); end end
module cffim_fault_mask_tb;
  reg core_clk = 0, rst = 1, regRstCmd = 0, regWrite = 0;
  reg [7:0] regAddr = 8'h00, regWrData = 8'h00;
  reg [27:0] flip = 28'h0;
  wire [7:0] regRdData;
  wire [27:0] lvl;
  wire irqPulse;
  int mismatches = 0, samplesChecked = 0, pulses = 0, k;
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (irqPulse === 1'b1) pulses++;
  cffim_event_src src (.core_clk, .rst, .flip, .lvl);
  // event k sits at mask register k/8, bit k%8; flags at 24..27
  cffim_fault_mask dut (.core_clk, .rst, .regRstCmd, .regWrite, .regAddr, .regWrData,
    .regRdData, .irqPulse, .input1OvDet(lvl[24]), .sysShortDet(lvl[25]),
    .sysOvStopDet(lvl[26]), .thermalShutDet(lvl[27]), .inputCurrentRegEnter(lvl[7]),
    .inputVoltageRegEnter(lvl[6]), .hostWatchdogExpire(lvl[5]), .weakSourceDet(lvl[4]),
    .powerGood(lvl[3]), .input2Present(lvl[2]), .input1Present(lvl[1]),
    .busInputPresent(lvl[0]), .chargeStateChange(lvl[15]), .optimizerStateChange(lvl[14]),
    .busInputStateChange(lvl[12]), .thermalRegEnter(lvl[10]), .batteryPresent(lvl[9]),
    .portDetectChange(lvl[8]), .dataLineDetectDone(lvl[22]), .conversionDone(lvl[21]),
    .minSysRegChange(lvl[20]), .fastChargeTimerExpire(lvl[19]),
    .trickleTimerExpire(lvl[18]), .prechargeTimerExpire(lvl[17]),
    .topoffTimerExpire(lvl[16]));
  task wr(input [7:0] a, input [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    // address held five samples so the flag checks in the checker can see it
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(regRdData, e)
  endtask
  // one-cycle flip, then room for sync and edge detect to settle
  task tog(input [27:0] f);
    @(posedge core_clk);
    flip <= f;
    @(posedge core_clk);
    flip <= 28'h0;
    repeat (8) @(posedge core_clk);
  endtask
  task fire(input int b, input [7:0] m);
    int n;
    wr(8'(8'h28 + b / 8), m);
    @(negedge core_clk);
    n = pulses;
    tog(28'h1 << b);
    @(negedge core_clk);
    `CHK(pulses - n, (m == 8'h00) ? 1 : 0)
    // falling back is left uncounted: some events fire on both edges
    tog(28'h1 << b);
  endtask
  task printVerdict;
    $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (k = 8'h26; k <= 8'h2a; k++) rd(8'(k), 8'h00);
    rd(8'h30, 8'h00);
    wr(8'h28, 8'hff);
    wr(8'h29, 8'hff);
    wr(8'h2a, 8'hff);
    wr(8'h27, 8'hff);
    rd(8'h28, 8'hff);
    rd(8'h29, 8'hd7);
    rd(8'h2a, 8'h7f);
    rd(8'h27, 8'h00);
    @(posedge core_clk);
    regRstCmd <= 1'b1;
    regAddr <= 8'h28;
    @(posedge core_clk);
    regRstCmd <= 1'b0;
    for (k = 8'h28; k <= 8'h2a; k++) rd(8'(k), 8'h00);
    tog(28'hf000000);
    rd(8'h26, 8'h01);
    rd(8'h27, 8'hc4);
    tog(28'hf000000);
    rd(8'h26, 8'h00);
    rd(8'h27, 8'h00);
    for (k = 0; k < 23; k++) begin
      if (k != 11 && k != 13) begin
        fire(k, 8'h00);
        fire(k, 8'(1 << (k % 8)));
      end
    end
    printVerdict();
  end
endmodule // cffim_fault_mask_tb
